/* design/pwmd_pkg.sv */
package pwmd_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int AXI_ADDR_W = 8;
   localparam int CTRL_W = 5;
   localparam int STAT_W = 4;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] PERIOD_OFF = 8'h04;
   localparam logic [7:0] DUTY_OFF = 8'h08;
   localparam logic [7:0] COUNT_OFF = 8'h0C;
   localparam logic [7:0] STATUS_OFF = 8'h10;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_LE_BIT = 1;
   localparam int CTRL_SRC_TC_BIT = 2;
   localparam int CTRL_INV_EN_BIT = 3;
   localparam int CTRL_IRQ_EN_BIT = 4;
   localparam int STAT_OUT_BIT = 0;
   localparam int STAT_TC_BIT = 1;
   localparam int STAT_EN_BIT = 2;
   localparam int STAT_RUN_BIT = 3;

   // ------------------------------------------------------------
   // reset values and bus answers
   // ------------------------------------------------------------
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   localparam logic [7:0] DUTY_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SEL_CTRL,
      SEL_PERIOD,
      SEL_DUTY,
      SEL_COUNT,
      SEL_STATUS,
      SEL_NONE
   } pwmd_sel_t;
endpackage

/* design/pwmd_core_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pwmd_core_if #(parameter int W = 8);
   logic run;
   logic cmp_le;
   logic src_tc;
   logic irq_en;
   logic en;
   logic load_count;
   logic [W-1:0] load_val;
   logic [W-1:0] period;
   logic [W-1:0] duty;
   logic [W-1:0] count;
   logic out;
   logic tc;
   logic irq;

   modport ctl (
      output run, cmp_le, src_tc, irq_en, en, load_count, load_val,
      output period, duty,
      input count, out, tc, irq
   );
   modport core (
      input run, cmp_le, src_tc, irq_en, en, load_count, load_val,
      input period, duty,
      output count, out, tc, irq
   );
endinterface
`default_nettype wire

/* design/pwmd_core.sv */
`timescale 1ns/100ps
`default_nettype none
module pwmd_core
   import pwmd_pkg::*;
#(
   parameter int W = DATA_W
)
(
   input wire logic mclk_i,
   input wire logic reset_i,
   pwmd_core_if.core cif
);
   logic [W-1:0] count_r;
   logic out_r;
   logic tc_r;
   logic irq_r;
   logic step;
   logic tc_nxt;
   logic cmp_nxt;
   logic rise_nxt;
   logic [W:0] gap_r;
   logic steady_r;
   logic [W-1:0] period_q_r;

   // ------------------------------------------------------------
   // counter and comparator
   // ------------------------------------------------------------
   assign step = cif.run & cif.en;
   assign tc_nxt = step & (count_r == '0);
   assign cmp_nxt = cif.cmp_le ? (count_r <= cif.duty) : (count_r < cif.duty);
   assign rise_nxt = cif.run & cmp_nxt & ~out_r;

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         count_r <= W'(PERIOD_RST);
      else if (cif.load_count)
         count_r <= cif.load_val;
      else if (tc_nxt)
         count_r <= cif.period;
      else if (step)
         count_r <= count_r - W'(1);
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         out_r <= 1'b0;
      else
         out_r <= cif.run & cmp_nxt;
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         tc_r <= 1'b0;
      else
         tc_r <= tc_nxt;
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         irq_r <= 1'b0;
      else
         irq_r <= cif.irq_en & (cif.src_tc ? tc_nxt : rise_nxt);
   end

   assign cif.count = count_r;
   assign cif.out = out_r;
   assign cif.tc = tc_r;
   assign cif.irq = irq_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      period_q_r <= cif.period;
      if (reset_i || !step || cif.load_count)
      begin
         gap_r <= '0;
         steady_r <= 1'b0;
      end
      else if (tc_nxt)
      begin
         gap_r <= (W+1)'(1);
         steady_r <= 1'b1;
      end
      else
      begin
         gap_r <= gap_r + (W+1)'(1);
         if (cif.period != period_q_r)
            steady_r <= 1'b0;
      end
   end

   a_count_decrement: assert property (@(posedge mclk_i) disable iff (reset_i)
      step && !cif.load_count && count_r != '0 |=>
      count_r == $past(count_r) - W'(1)) else $error("count did not step");
   a_count_reload: assert property (@(posedge mclk_i) disable iff (reset_i)
      tc_nxt && !cif.load_count |=> count_r == $past(cif.period))
      else $error("count not reloaded");
   a_count_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
      !step && !cif.load_count |=> $stable(count_r))
      else $error("count moved while idle");
   a_period_length: assert property (@(posedge mclk_i) disable iff (reset_i)
      tc_nxt && steady_r && cif.period == period_q_r |->
      gap_r == {1'b0, cif.period} + (W+1)'(1))
      else $error("period length wrong");
   a_out_stopped: assert property (@(posedge mclk_i) disable iff (reset_i)
      !cif.run |=> !out_r ##0 $stable(count_r) || $past(cif.load_count))
      else $error("output high while stopped");
   a_compare_result: assert property (@(posedge mclk_i) disable iff (reset_i)
      cif.run |=> out_r == ($past(cif.cmp_le) ?
      ($past(count_r) <= $past(cif.duty)) : ($past(count_r) < $past(cif.duty))))
      else $error("compare result wrong");
   a_tc_pulse: assert property (@(posedge mclk_i) disable iff (reset_i)
      tc_r |-> count_r == $past(cif.period) && $past(step))
      else $error("terminal count without reload");
   a_irq_select: assert property (@(posedge mclk_i) disable iff (reset_i)
      1'b1 |=> irq_r == ($past(cif.irq_en) && ($past(cif.src_tc) ?
      tc_r : (out_r && !$past(out_r)))))
      else $error("interrupt source wrong");
endmodule
`default_nettype wire

/* design/pwmd_top.sv */
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pwmd_top
   import pwmd_pkg::*;
#(
   parameter int W = DATA_W,
   parameter int ADDR_W = AXI_ADDR_W
)
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic pwm_out_o,
   output logic tc_o,
   output logic irq_o
);
   logic awready_r;
   logic aw_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic wready_r;
   logic w_held_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic aw_hs;
   logic w_hs;
   logic b_hs;
   logic ar_hs;
   logic r_hs;
   logic do_wr;
   pwmd_sel_t wr_sel;
   pwmd_sel_t rd_sel;
   logic [31:0] wr_old;
   logic [31:0] wr_word;
   logic [W-1:0] wr_val;
   logic [31:0] rd_word;
   logic [CTRL_W-1:0] ctrl_r;
   logic [W-1:0] period_r;
   logic [W-1:0] duty_r;
   logic en_s1_r;
   logic en_s2_r;
   logic en_s3_r;
   logic en_lvl_r;

   pwmd_core_if #(.W(W)) cif ();

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic pwmd_sel_t reg_decode(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] wa;
      wa = {a[ADDR_W-1:2], 2'b00};
      if (wa == ADDR_W'(CTRL_OFF))
         return SEL_CTRL;
      else if (wa == ADDR_W'(PERIOD_OFF))
         return SEL_PERIOD;
      else if (wa == ADDR_W'(DUTY_OFF))
         return SEL_DUTY;
      else if (wa == ADDR_W'(COUNT_OFF))
         return SEL_COUNT;
      else if (wa == ADDR_W'(STATUS_OFF))
         return SEL_STATUS;
      else
         return SEL_NONE;
   endfunction

   function automatic logic [31:0] reg_word(input pwmd_sel_t sel);
      logic [31:0] v;
      v = '0;
      case (sel)
         SEL_CTRL:
            v = 32'(ctrl_r);
         SEL_PERIOD:
            v = 32'(period_r);
         SEL_DUTY:
            v = 32'(duty_r);
         SEL_COUNT:
            v = 32'(cif.count);
         SEL_STATUS:
         begin
            v[STAT_OUT_BIT] = cif.out;
            v[STAT_TC_BIT] = cif.tc;
            v[STAT_EN_BIT] = cif.en;
            v[STAT_RUN_BIT] = ctrl_r[CTRL_RUN_BIT];
         end
         default:
            v = '0;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // write channels
   // ------------------------------------------------------------
   assign aw_hs = s_axi_awvalid_i & awready_r;
   assign w_hs = s_axi_wvalid_i & wready_r;
   assign b_hs = bvalid_r & s_axi_bready_i;
   assign do_wr = aw_held_r & w_held_r & ~bvalid_r;
   assign wr_sel = reg_decode(awaddr_r);
   assign wr_val = wr_word[W-1:0];

   always_comb
   begin
      wr_old = reg_word(wr_sel);
      wr_word = wr_old;
      for (int i = 0; i < 4; i++)
      begin
         if (wstrb_r[i])
            wr_word[8*i +: 8] = wdata_r[8*i +: 8];
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         awready_r <= 1'b0;
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end
      else if (aw_hs)
      begin
         awready_r <= 1'b0;
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr_i;
      end
      else if (do_wr)
         aw_held_r <= 1'b0;
      else if (!aw_held_r && !bvalid_r)
         awready_r <= 1'b1;
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         wready_r <= 1'b0;
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end
      else if (w_hs)
      begin
         wready_r <= 1'b0;
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata_i;
         wstrb_r <= s_axi_wstrb_i;
      end
      else if (do_wr)
         w_held_r <= 1'b0;
      else if (!w_held_r && !bvalid_r)
         wready_r <= 1'b1;
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (b_hs)
         bvalid_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // read channels
   // ------------------------------------------------------------
   assign ar_hs = s_axi_arvalid_i & arready_r;
   assign r_hs = rvalid_r & s_axi_rready_i;
   assign rd_sel = reg_decode(s_axi_araddr_i);

   always_comb
   begin
      rd_word = reg_word(rd_sel);
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (r_hs)
         rvalid_r <= 1'b0;
      else if (!rvalid_r)
         arready_r <= 1'b1;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         ctrl_r <= CTRL_RST;
      else if (do_wr && wr_sel == SEL_CTRL)
         ctrl_r <= wr_word[CTRL_W-1:0];
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         period_r <= W'(PERIOD_RST);
      else if (do_wr && wr_sel == SEL_PERIOD)
         period_r <= wr_val;
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         duty_r <= W'(DUTY_RST);
      else if (do_wr && wr_sel == SEL_DUTY)
         duty_r <= wr_val;
      else if (ar_hs && rd_sel == SEL_COUNT)
         duty_r <= cif.count;
   end

   // ------------------------------------------------------------
   // enable input synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         en_s1_r <= 1'b0;
         en_s2_r <= 1'b0;
         en_s3_r <= 1'b0;
         en_lvl_r <= 1'b0;
      end
      else
      begin
         en_s1_r <= enable_i;
         en_s2_r <= en_s1_r;
         en_s3_r <= en_s2_r;
         if (en_s2_r == en_s3_r)
            en_lvl_r <= en_s3_r;
      end
   end

   // ------------------------------------------------------------
   // core hookup
   // ------------------------------------------------------------
   assign cif.run = ctrl_r[CTRL_RUN_BIT];
   assign cif.cmp_le = ctrl_r[CTRL_LE_BIT];
   assign cif.src_tc = ctrl_r[CTRL_SRC_TC_BIT];
   assign cif.irq_en = ctrl_r[CTRL_IRQ_EN_BIT];
   assign cif.en = en_lvl_r ^ ctrl_r[CTRL_INV_EN_BIT];
   assign cif.load_count = do_wr & (wr_sel == SEL_PERIOD) &
                           ~ctrl_r[CTRL_RUN_BIT];
   assign cif.load_val = wr_val;
   assign cif.period = period_r;
   assign cif.duty = duty_r;

   pwmd_core #(.W(W)) u_core (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .cif(cif.core)
   );

   assign s_axi_awready_o = awready_r;
   assign s_axi_wready_o = wready_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_arready_o = arready_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign pwm_out_o = cif.out;
   assign tc_o = cif.tc;
   assign irq_o = cif.irq;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_stopped_load: assert property (@(posedge mclk_i) disable iff (reset_i)
      do_wr && wr_sel == SEL_PERIOD && !ctrl_r[CTRL_RUN_BIT] |=>
      cif.count == $past(wr_val) && period_r == $past(wr_val))
      else $error("stopped period write missed count");
   a_running_period: assert property (@(posedge mclk_i) disable iff (reset_i)
      do_wr && wr_sel == SEL_PERIOD && ctrl_r[CTRL_RUN_BIT] && !cif.en |=>
      $stable(cif.count)) else $error("running period write moved count");
   a_count_copy: assert property (@(posedge mclk_i) disable iff (reset_i)
      ar_hs && rd_sel == SEL_COUNT && !(do_wr && wr_sel == SEL_DUTY) |=>
      duty_r == $past(cif.count) && rdata_r == 32'($past(cif.count)))
      else $error("count read did not copy");
   a_duty_next_cycle: assert property (@(posedge mclk_i) disable iff (reset_i)
      do_wr && wr_sel == SEL_DUTY && wstrb_r[0] |=>
      duty_r == $past(wr_val) ##1 (!ctrl_r[CTRL_RUN_BIT] || (pwm_out_o ==
      ($past(cif.cmp_le) ? ($past(cif.count) <= $past(duty_r)) :
      ($past(cif.count) < $past(duty_r))))))
      else $error("threshold write late");
   a_enable_sense: assert property (@(posedge mclk_i) disable iff (reset_i)
      en_s2_r == en_s3_r |=> en_lvl_r == $past(en_s3_r) ##0
      cif.en == (en_lvl_r != ctrl_r[CTRL_INV_EN_BIT]))
      else $error("enable sense wrong");
   a_write_answer: assert property (@(posedge mclk_i) disable iff (reset_i)
      do_wr |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
      else $error("write answer missing");
   a_read_answer: assert property (@(posedge mclk_i) disable iff (reset_i)
      ar_hs |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("read answer missing");
   a_run_stops: assert property (@(posedge mclk_i) disable iff (reset_i)
      !ctrl_r[CTRL_RUN_BIT] && !cif.load_count |=> $stable(cif.count))
      else $error("stopped counter moved");
endmodule
`default_nettype wire

/* tb/pwmd_pin_mon.sv */
`timescale 1ns/100ps
`default_nettype none
module pwmd_pin_mon
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic pwm_i,
   input wire logic tc_i,
   output logic [8:0] per_o,
   output logic [8:0] hi_o,
   output logic done_o
);
   // ------------------------------------------------------------
   // pin side: one report per reload window
   // ------------------------------------------------------------
   logic [8:0] cyc_r;
   logic [8:0] hic_r;
   always_ff @(posedge mclk_i)
   begin
      if (reset_i || tc_i)
      begin
         cyc_r <= 9'h000;
         hic_r <= 9'h000;
      end
      else
      begin
         cyc_r <= cyc_r + 9'h001;
         hic_r <= hic_r + {8'h00, pwm_i};
      end
   end
   always_ff @(posedge mclk_i)
   begin
      done_o <= tc_i && !reset_i;
      per_o <= cyc_r + 9'h001;
      hi_o <= hic_r + {8'h00, pwm_i};
   end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import pwmd_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic mclk_i, reset_i, enable_i, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic awready, wready, bvalid, arready, rvalid, pwm_o, tc_o, irq_o, done;
   logic [1:0] bresp, rresp;
   logic [8:0] per, hi;
   logic [33:0] rq[$], wq[$], mq[$];
   logic [33:0] e_v;
   int failures, num_checks, seed;
   pwmd_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .enable_i(enable_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .pwm_out_o(pwm_o), .tc_o(tc_o), .irq_o(irq_o));
   pwmd_pin_mon pin_u (.mclk_i(mclk_i), .reset_i(reset_i), .pwm_i(pwm_o),
      .tc_i(tc_o), .per_o(per), .hi_o(hi), .done_o(done));
   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // ------------------------------------------------------------
   // checking
   // ------------------------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task final_report;
      // expectations never answered count as mismatches
      failures += rq.size() + wq.size() + mq.size();
      $display("checks=%0d mismatches=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task tmo;
      failures++;
      $display("[FAIL] t=%0t wait ran out seen=%h exp=%h", $time, 1'b0, 1'b1);
      final_report();
   endtask
   always @(posedge mclk_i)
   begin
      if (rvalid && rready && rq.size() > 0)
      begin
         e_v = rq.pop_front();
         check({rresp, rdata}, e_v);
      end
      if (bvalid && bready && wq.size() > 0)
      begin
         e_v = wq.pop_front();
         check({32'h0, bresp}, e_v);
      end
      if (done && mq.size() > 0)
      begin
         e_v = mq.pop_front();
         check({16'h0, per, hi}, e_v);
      end
   end
   // ------------------------------------------------------------
   // bus and wait tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      logic ga, gw, gb;
      ga = 1'b0;
      gw = 1'b0;
      gb = 1'b0;
      wq.push_back({32'h0, er});
      @(posedge mclk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100 && !(ga && gw); n++)
      begin
         @(posedge mclk_i);
         if (awready)
         begin
            ga = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready)
         begin
            gw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      for (n = 0; n < 100 && !gb; n++)
      begin
         if (n > 0 || !(ga && gw))
            @(posedge mclk_i);
         gb = bvalid;
      end
      if (!gb)
         tmo();
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      logic g;
      g = 1'b0;
      rq.push_back(e);
      @(posedge mclk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100 && !g; n++)
      begin
         @(posedge mclk_i);
         g = arready;
      end
      arvalid <= 1'b0;
      g = 1'b0;
      for (n = 0; n < 100 && !g; n++)
      begin
         @(posedge mclk_i);
         g = rvalid;
      end
      if (!g)
         tmo();
      rready <= 1'b0;
   endtask
   task automatic wait_sig(input int k);
      int n;
      logic hit, prev;
      hit = 1'b0;
      prev = pwm_o;
      for (n = 0; n < 2000 && !hit; n++)
      begin
         @(negedge mclk_i);
         hit = (k == 0) ? (done === 1'b1) : (k == 1) ? (tc_o === 1'b1) :
               (pwm_o === 1'b1 && prev === 1'b0);
         prev = pwm_o;
      end
      if (!hit)
         tmo();
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial
   begin
      int i;
      logic [31:0] r;
      logic [16:0] cfg;
      logic [8:0] eh;
      logic [16:0] tbl[5];
      tbl = '{{8'h00, 8'h05, 1'b0}, 17'h0, 17'h1, {8'h07, 8'h07, 1'b0},
              {8'h07, 8'h09, 1'b0}};
      seed = 6556;
      failures = 0;
      num_checks = 0;
      {reset_i, enable_i} = 2'b11;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      rd(CTRL_OFF, {RESP_OKAY, 27'h0, CTRL_RST});
      rd(PERIOD_OFF, {RESP_OKAY, 24'h0, PERIOD_RST});
      rd(DUTY_OFF, {RESP_OKAY, 24'h0, DUTY_RST});
      rd(COUNT_OFF, {RESP_OKAY, 32'h0000_00FF});
      rd(DUTY_OFF, {RESP_OKAY, 32'h0000_00FF});
      rd(8'h14, {RESP_SLVERR, 32'h0});
      wr(8'h14, 32'h0, RESP_SLVERR);
      $display("test reset and map done");
      wr(PERIOD_OFF, 32'h20, RESP_OKAY);
      rd(COUNT_OFF, {RESP_OKAY, 32'h20});
      check({33'h0, pwm_o}, 34'h0);
      wr(CTRL_OFF, 32'h09, RESP_OKAY);
      repeat (20) @(negedge mclk_i);
      rd(COUNT_OFF, {RESP_OKAY, 32'h20});
      wr(PERIOD_OFF, 32'h30, RESP_OKAY);
      rd(COUNT_OFF, {RESP_OKAY, 32'h20});
      rd(PERIOD_OFF, {RESP_OKAY, 32'h30});
      wr(DUTY_OFF, 32'h05, RESP_OKAY);
      rd(DUTY_OFF, {RESP_OKAY, 32'h05});
      rd(COUNT_OFF, {RESP_OKAY, 32'h20});
      rd(DUTY_OFF, {RESP_OKAY, 32'h20});
      wr(DUTY_OFF, 32'h05, RESP_OKAY);
      rd(DUTY_OFF, {RESP_OKAY, 32'h05});
      $display("test hold and polarity done");
      for (i = 0; i < 9; i++)
      begin
         r = $random(seed);
         cfg = (i < 5) ? tbl[i] : {3'h0, r[4:0] + 5'h01, 3'h0, r[12:8], r[16]};
         wr(PERIOD_OFF, {24'h0, cfg[16:9]}, RESP_OKAY);
         wr(DUTY_OFF, {24'h0, cfg[8:1]}, RESP_OKAY);
         wr(CTRL_OFF, {30'h0, cfg[0], 1'b1}, RESP_OKAY);
         eh = {1'b0, cfg[8:1]} + {8'h00, cfg[0]};
         if (eh > {1'b0, cfg[16:9]} + 9'h001)
            eh = {1'b0, cfg[16:9]} + 9'h001;
         wait_sig(0);
         wait_sig(0);
         mq.push_back({16'h0, {1'b0, cfg[16:9]} + 9'h001, eh});
         repeat (2) @(posedge mclk_i);
      end
      $display("test period and duty done");
      wr(PERIOD_OFF, 32'h07, RESP_OKAY);
      wr(DUTY_OFF, 32'h03, RESP_OKAY);
      wr(CTRL_OFF, 32'h15, RESP_OKAY);
      wait_sig(1);
      check({33'h0, irq_o}, 34'h1);
      wr(DUTY_OFF, 32'h02, RESP_OKAY);
      wr(CTRL_OFF, 32'h05, RESP_OKAY);
      wait_sig(1);
      check({33'h0, irq_o}, 34'h0);
      wr(CTRL_OFF, 32'h11, RESP_OKAY);
      wait_sig(2);
      check({33'h0, irq_o}, 34'h1);
      $display("test interrupt done");
      wr(CTRL_OFF, 32'h00, RESP_OKAY);
      repeat (3) @(negedge mclk_i);
      check({32'h0, pwm_o, tc_o}, 34'h0);
      $display("test stop done");
      final_report();
   end
endmodule
`default_nettype wire
